// ---- core/dci_params.svh ----
`ifndef DCI_PARAMS_SVH
`define DCI_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DCI_OFS_MODE_A 8'h00
`define DCI_OFS_MODE_B 8'h04
`define DCI_OFS_EXT_A 8'h08
`define DCI_OFS_EXT_B 8'h0c
`define DCI_OFS_VEC_A 8'h10
`define DCI_OFS_VEC_B 8'h14
`define DCI_OFS_MASTER 8'h18
`define DCI_OFS_PEND 8'h1c
`define DCI_OFS_CMD 8'h20
`define DCI_OFS_ISRV 8'h24
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCI_M_EXT_IE 0
`define DCI_M_TX_IE 1
`define DCI_M_RX_LO 3
`define DCI_M_WR_FUNC 5
`define DCI_M_WR_EN 6
`define DCI_M_WR_RX 7
`define DCI_X_RX_FOUR 3
`define DCI_X_DTR_REQ 4
`define DCI_X_TX_ALL 5
`define DCI_G_VIS 0
`define DCI_G_MIE 3
`define DCI_C_ACK 0
`define DCI_C_RST_IUS 1
`define DCI_C_CLR_LO 8
// ----------------------------------------
// Reset values and vector status codes
// ----------------------------------------
`define DCI_RST_BYTE 8'h00
`define DCI_ST_B_TX 3'h0
`define DCI_ST_B_EXT 3'h1
`define DCI_ST_B_RX 3'h2
`define DCI_ST_B_SPC 3'h3
`define DCI_ST_A_TX 3'h4
`define DCI_ST_A_EXT 3'h5
`define DCI_ST_A_RX 3'h6
`define DCI_ST_A_SPC 3'h7
`define DCI_VEC_ST_LO 1
`endif

// ---- core/dci_pkg.sv ----
package dci_pkg;
    // Per-channel events, all on hclk
    typedef struct packed {
        logic tx_write;
        logic tx_load;
        logic tx_empty;
        logic rx_char;
        logic rx_four;
        logic rx_special;
        logic underrun;
        logic brg_zero;
        logic brk;
        logic abort_seq;
        logic end_of_poll;
        logic rx_ready;
        logic tx_ready;
    } dci_ev_t;
    // Modem pins, asynchronous to hclk
    typedef struct packed {
        logic cts;
        logic carrier_detect_in;
        logic sync;
    } dci_pins_t;
    typedef enum logic [1:0] {
        RX_OFF,
        RX_FIRST,
        RX_ALL,
        RX_SPECIAL
    } dci_rx_mode_t;
    typedef enum logic {
        ACK_IDLE,
        ACK_HOLD
    } dci_ack_st_t;
endpackage

// ---- core/dci_top.sv ----
`include "dci_params.svh"
// Functional notes
// - On acknowledge, the chosen device drives its vector onto the data lines.
// - Optionally three vector bits carry source status; channel B read shows it.
// - Six sources each keep pending, in-service and enable bits.
// - Requests need the source enable and the global request gate.
// - Source enable bits are write-only; they read back as zero.
// - Request output low only while chain input high and something pends.
// - Pending never sets with enable clear; all pending bits in one register.
// - Any in-service bit blocks lower sources and drives chain output low.
// - Acknowledge sets in-service only when no higher device requests.
// - Finished acknowledge releases the request output, allowing nesting.
// - Channel A over B; transmit, receive, external within a channel.
// - A software acknowledge command sets in-service and latches the vector but never drives the data lines.
// - Whole-empty interrupt only after a written character moved out.
// - Receive interrupt modes: first character, every character, special only.
// - Extended bit 3 with special-only mode interrupts at four bytes.
// - Special receive conditions differ only by the vector status.
// - In first mode specials interrupt any time after the first character.
// - External interrupt from pin changes, underrun, zero count, break, abort, poll.
// - Abort and end of poll interrupt at start and at end.
// - Wait output low while not ready; in request mode low when ready.
// - One shared vector register, written through either channel.
module dci_top #(
    parameter int ADDR_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic chain_enable_in,
    output logic chain_enable_out,
    output logic int_req_n,
    input wire logic acknowledge_strobe_in,
    output logic [7:0] ack_vector,
    output logic ack_vector_oe,
    input wire dci_pkg::dci_ev_t [1:0] ch_ev,
    input wire dci_pkg::dci_pins_t [1:0] ch_pins,
    output logic [1:0] wait_req_n,
    output logic [1:0] dtr_req_n
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] mode_r [2];
    logic [7:0] mode_nxt [2];
    logic [7:0] ext_r [2];
    logic [7:0] ext_nxt [2];
    logic [7:0] vec_r, vec_nxt;
    logic [7:0] master_r, master_nxt;
    logic [5:0] ip_r, ip_nxt;
    logic [5:0] ius_r, ius_nxt;
    logic [1:0] spc_r, spc_nxt;
    logic [1:0] first_r, first_nxt;
    logic [1:0] txw_r, txw_nxt;
    logic [5:0] lvl_r, lvl_nxt;
    logic [1:0] four_r, four_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic wr_r, wr_nxt, rd_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [7:0] ackv_r, ackv_nxt;
    logic ackoe_r, ackoe_nxt;
    dci_pkg::dci_ack_st_t ack_st_r, ack_st_nxt;
    logic [1:0] wrq_r, wrq_nxt;
    logic [1:0] dtr_r, dtr_nxt;
    // Two-stage synchronisers; stage one feeds only stage two
    logic cei_s1, cei_s2;
    logic ack_s1, ack_s2, ack_s3;
    logic [5:0] pin_s1, pin_s2, pin_s3;
    logic [5:0] req;
    logic [5:0] pend_ok;
    logic any_req;
    logic [2:0] top_idx;
    logic [2:0] top_code;
    // ----------------------------------------
    // Priority chain
    // ----------------------------------------
    // Source i = 3*channel + k, k: 0 tx, 1 rx, 2 ext; index 0 ranks highest
    always_comb begin
        logic blocked;
        logic global_request_gate;
        logic found;
        blocked = 1'b0;
        global_request_gate = master_r[`DCI_G_MIE];
        found = 1'b0;
        req = '0;
        pend_ok = '0;
        top_idx = 3'h0;
        any_req = 1'b0;
        for (int i = 0; i < 6; i++) begin
            pend_ok[i] = ip_r[i] & global_request_gate;
            // A source in service blocks itself too, or its still-set
            // pending bit would pull the request pin again after acknowledge
            blocked = blocked | ius_r[i];
            req[i] = pend_ok[i] & ~blocked & cei_s2;
            // Status names the highest pending source; whenever any source
            // asks, that one is also the winner of the chain
            if (pend_ok[i] && !found) begin
                top_idx = 3'(i);
                found = 1'b1;
            end
            any_req = any_req | req[i];
            blocked = blocked | req[i];
        end
    end
    // Status code of the winning source; special receive has its own
    always_comb begin
        unique case (top_idx)
            3'h0: top_code = `DCI_ST_A_TX;
            3'h1: top_code = spc_r[0] ? `DCI_ST_A_SPC : `DCI_ST_A_RX;
            3'h2: top_code = `DCI_ST_A_EXT;
            3'h3: top_code = `DCI_ST_B_TX;
            3'h4: top_code = spc_r[1] ? `DCI_ST_B_SPC : `DCI_ST_B_RX;
            3'h5: top_code = `DCI_ST_B_EXT;
            default: top_code = `DCI_ST_B_TX;
        endcase
    end
    // Request pin low only while a source wins the chain
    assign int_req_n = ~any_req;
    // Downstream blocked while any source here is served or asking
    assign chain_enable_out = cei_s2 & ~(|ius_r) & ~(|pend_ok);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;
    assign ack_vector = ackv_r;
    assign ack_vector_oe = ackoe_r;
    assign wait_req_n = wrq_r;
    assign dtr_req_n = dtr_r;
    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [5:0] set_ev;
        logic [5:0] clr;
        logic [31:0] wd;
        logic do_ack;
        logic [7:0] mod_vec;
        logic ev_tx, ev_rx, ev_ext, rdy, on;
        dci_pkg::dci_rx_mode_t rxm;
        set_ev = '0;
        clr = '0;
        wd = hwdata;
        do_ack = 1'b0;
        mod_vec = vec_r;
        ev_tx = 1'b0;
        ev_rx = 1'b0;
        ev_ext = 1'b0;
        rdy = 1'b0;
        on = 1'b0;
        rxm = dci_pkg::RX_OFF;
        for (int c = 0; c < 2; c++) begin
            mode_nxt[c] = mode_r[c];
            ext_nxt[c] = ext_r[c];
        end
        vec_nxt = vec_r;
        master_nxt = master_r;
        ius_nxt = ius_r;
        spc_nxt = spc_r;
        first_nxt = first_r;
        txw_nxt = txw_r;
        ackv_nxt = ackv_r;
        ackoe_nxt = ackoe_r;
        ack_st_nxt = ack_st_r;
        // Modified vector: status replaces bits 1 to 3
        if (master_r[`DCI_G_VIS]) begin
            mod_vec[`DCI_VEC_ST_LO +: 3] = top_code;
        end
        // Bus address phase captured; zero wait states
        addr_nxt = addr_r;
        wr_nxt = 1'b0;
        rd_nxt = hsel & htrans[1] & hready & ~hwrite;
        if (hsel && htrans[1] && hready) begin
            addr_nxt = haddr[7:0];
            wr_nxt = hwrite;
        end
        // Read data is settled in the address phase, so the data phase
        // gets it from a flop; a read right after a write sees old data
        rdata_nxt = 32'h0;
        if (rd_nxt) begin
            unique case (haddr[7:0])
                `DCI_OFS_MODE_A: rdata_nxt = {24'h0, mode_r[0] & 8'hfc};
                `DCI_OFS_MODE_B: rdata_nxt = {24'h0, mode_r[1] & 8'hfc};
                `DCI_OFS_EXT_A: rdata_nxt = {24'h0, ext_r[0]};
                `DCI_OFS_EXT_B: rdata_nxt = {24'h0, ext_r[1]};
                `DCI_OFS_VEC_A: rdata_nxt = {24'h0, vec_r};
                `DCI_OFS_VEC_B: rdata_nxt = {24'h0, mod_vec};
                `DCI_OFS_MASTER: rdata_nxt = {24'h0, master_r};
                `DCI_OFS_PEND: rdata_nxt = {26'h0, ip_r};
                `DCI_OFS_ISRV: rdata_nxt = {26'h0, ius_r};
                default: rdata_nxt = 32'h0;
            endcase
        end
        // Data-phase writes
        if (wr_r) begin
            unique case (addr_r)
                `DCI_OFS_MODE_A: begin
                    mode_nxt[0] = wd[7:0];
                    first_nxt[0] = 1'b0;
                end
                `DCI_OFS_MODE_B: begin
                    mode_nxt[1] = wd[7:0];
                    first_nxt[1] = 1'b0;
                end
                `DCI_OFS_EXT_A: ext_nxt[0] = wd[7:0];
                `DCI_OFS_EXT_B: ext_nxt[1] = wd[7:0];
                `DCI_OFS_VEC_A: vec_nxt = wd[7:0];
                `DCI_OFS_VEC_B: vec_nxt = wd[7:0];
                `DCI_OFS_MASTER: master_nxt = wd[7:0];
                `DCI_OFS_CMD: begin
                    clr = wd[`DCI_C_CLR_LO +: 6];
                    do_ack = wd[`DCI_C_ACK];
                    // Release the highest in-service source only
                    if (wd[`DCI_C_RST_IUS]) begin
                        ius_nxt = ius_r & (ius_r - 6'h1);
                    end
                end
                default: ;
            endcase
        end
        // Source events per channel
        for (int c = 0; c < 2; c++) begin
            rxm = dci_pkg::dci_rx_mode_t'(mode_r[c][`DCI_M_RX_LO +: 2]);
            // Written-since flag for whole-FIFO-empty
            if (ch_ev[c].tx_write) begin
                txw_nxt[c] = 1'b1;
            end
            if (ext_r[c][`DCI_X_TX_ALL]) begin
                ev_tx = ch_ev[c].tx_load & ch_ev[c].tx_empty & txw_r[c];
                if (ev_tx && !ch_ev[c].tx_write) begin
                    txw_nxt[c] = 1'b0;
                end
            end else begin
                ev_tx = ch_ev[c].tx_load;
            end
            unique case (rxm)
                dci_pkg::RX_OFF: ev_rx = 1'b0;
                dci_pkg::RX_FIRST: ev_rx = (ch_ev[c].rx_char & ~first_r[c])
                    | (ch_ev[c].rx_special & first_r[c]);
                dci_pkg::RX_ALL: ev_rx = ch_ev[c].rx_char | ch_ev[c].rx_special;
                dci_pkg::RX_SPECIAL: ev_rx = ch_ev[c].rx_special
                    | (ext_r[c][`DCI_X_RX_FOUR] & ch_ev[c].rx_four & ~four_r[c]);
            endcase
            if (rxm == dci_pkg::RX_FIRST && ch_ev[c].rx_char) begin
                first_nxt[c] = 1'b1;
            end
            // Any change of a level condition, both edges, plus pulses
            ev_ext = (|(pin_s2[3*c +: 3] ^ pin_s3[3*c +: 3]))
                | (ch_ev[c].brk ^ lvl_r[3*c])
                | (ch_ev[c].abort_seq ^ lvl_r[3*c+1])
                | (ch_ev[c].end_of_poll ^ lvl_r[3*c+2])
                | ch_ev[c].underrun | ch_ev[c].brg_zero;
            set_ev[3*c] = ev_tx & mode_r[c][`DCI_M_TX_IE];
            set_ev[3*c+1] = ev_rx;
            set_ev[3*c+2] = ev_ext & mode_r[c][`DCI_M_EXT_IE];
            if (ch_ev[c].rx_special && ev_rx) begin
                spc_nxt[c] = 1'b1;
            end else if (clr[3*c+1]) begin
                spc_nxt[c] = 1'b0;
            end
            // Wait or request pin
            rdy = mode_r[c][`DCI_M_WR_RX] ? ch_ev[c].rx_ready : ch_ev[c].tx_ready;
            on = mode_r[c][`DCI_M_WR_EN];
            if (mode_r[c][`DCI_M_WR_FUNC]) begin
                wrq_nxt[c] = ~(on & rdy);
            end else begin
                wrq_nxt[c] = ~(on & ~rdy);
            end
            dtr_nxt[c] = ext_r[c][`DCI_X_DTR_REQ] ? ~(on & rdy) : 1'b1;
        end
        for (int c = 0; c < 2; c++) begin
            lvl_nxt[3*c] = ch_ev[c].brk;
            lvl_nxt[3*c+1] = ch_ev[c].abort_seq;
            lvl_nxt[3*c+2] = ch_ev[c].end_of_poll;
            four_nxt[c] = ch_ev[c].rx_four;
        end
        // Set wins over a clear in the same cycle
        ip_nxt = (ip_r & ~clr) | set_ev;
        // Hardware acknowledge on the synchronised rising edge
        unique case (ack_st_r)
            dci_pkg::ACK_IDLE: begin
                if ((ack_s2 && !ack_s3) || do_ack) begin
                    if (any_req && cei_s2) begin
                        ius_nxt[top_idx] = 1'b1;
                        ackv_nxt = mod_vec;
                        ackoe_nxt = ~do_ack;
                    end
                    if (!do_ack) begin
                        ack_st_nxt = dci_pkg::ACK_HOLD;
                    end
                end
            end
            dci_pkg::ACK_HOLD: begin
                if (!ack_s2) begin
                    ackoe_nxt = 1'b0;
                    ack_st_nxt = dci_pkg::ACK_IDLE;
                end
            end
        endcase
    end
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int c = 0; c < 2; c++) begin
                mode_r[c] <= `DCI_RST_BYTE;
                ext_r[c] <= `DCI_RST_BYTE;
            end
            vec_r <= `DCI_RST_BYTE;
            master_r <= `DCI_RST_BYTE;
            ip_r <= 6'h0;
            ius_r <= 6'h0;
            spc_r <= 2'h0;
            first_r <= 2'h0;
            txw_r <= 2'h0;
            lvl_r <= 6'h0;
            four_r <= 2'h0;
            addr_r <= 8'h0;
            wr_r <= 1'b0;
            rdata_r <= 32'h0;
            ackv_r <= 8'h0;
            ackoe_r <= 1'b0;
            ack_st_r <= dci_pkg::ACK_IDLE;
            wrq_r <= 2'h3;
            dtr_r <= 2'h3;
            cei_s1 <= 1'b0;
            cei_s2 <= 1'b0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_s3 <= 1'b0;
            pin_s1 <= 6'h0;
            pin_s2 <= 6'h0;
            pin_s3 <= 6'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                mode_r[c] <= mode_nxt[c];
                ext_r[c] <= ext_nxt[c];
            end
            vec_r <= vec_nxt;
            master_r <= master_nxt;
            ip_r <= ip_nxt;
            ius_r <= ius_nxt;
            spc_r <= spc_nxt;
            first_r <= first_nxt;
            txw_r <= txw_nxt;
            lvl_r <= lvl_nxt;
            four_r <= four_nxt;
            addr_r <= addr_nxt;
            wr_r <= wr_nxt;
            rdata_r <= rdata_nxt;
            ackv_r <= ackv_nxt;
            ackoe_r <= ackoe_nxt;
            ack_st_r <= ack_st_nxt;
            wrq_r <= wrq_nxt;
            dtr_r <= dtr_nxt;
            cei_s1 <= chain_enable_in;
            cei_s2 <= cei_s1;
            ack_s1 <= acknowledge_strobe_in;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
            pin_s1 <= {ch_pins[1], ch_pins[0]};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end
endmodule // dci_top

// ---- verification/dci_assertions.sv ----
// ----------------------------------------
// Request chain and acknowledge checks
// ----------------------------------------
module dci_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic chain_enable_in,
    input wire logic chain_enable_out,
    input wire logic int_req_n,
    input wire logic acknowledge_strobe_in,
    input wire logic [7:0] ack_vector,
    input wire logic ack_vector_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dflt @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Chain input passes two synchroniser flops, so compare against its value two edges back
    AST_REQ_NEEDS_CHAIN: assert property (!int_req_n |-> $past(chain_enable_in, 2))
        else $error("request active while chain input was low");
    AST_REQ_BLOCKS_DOWN: assert property (!int_req_n |-> !chain_enable_out)
        else $error("downstream enabled while requesting");
    AST_CHAIN_IN_BLOCKS: assert property (!$past(chain_enable_in, 2) |-> !chain_enable_out)
        else $error("chain output high with chain input low");
    AST_OE_BLOCKS_DOWN: assert property (ack_vector_oe |-> !chain_enable_out)
        else $error("downstream enabled while in service");
    AST_ACK_NEEDS_REQ: assert property ($rose(ack_vector_oe) |-> $past(int_req_n) == 1'b0)
        else $error("vector driven without a request");
    AST_ACK_RELEASES: assert property ($rose(ack_vector_oe) |-> int_req_n)
        else $error("request still active after acknowledge");
    AST_VEC_NEEDS_STROBE: assert property ($rose(ack_vector_oe) |-> $past(acknowledge_strobe_in, 2))
        else $error("vector driven without acknowledge strobe");
    // Strobe low long enough to pass the synchroniser must release the data lines
    AST_OE_DROPS: assert property (!acknowledge_strobe_in [*5] |-> !ack_vector_oe)
        else $error("vector still driven after strobe fell");
    AST_VEC_STABLE: assert property (ack_vector_oe && $past(ack_vector_oe) |-> $stable(ack_vector))
        else $error("vector changed while driven");

    COV_ACK: cover property ($rose(ack_vector_oe));
    COV_REQ: cover property ($fell(int_req_n));
    COV_CHAIN_BLOCK: cover property (!int_req_n && $fell(chain_enable_in) ##2 int_req_n);
endmodule // dci_assertions

bind dci_top dci_assertions u_chk (
    .hclk, .hresetn, .chain_enable_in, .chain_enable_out, .int_req_n,
    .acknowledge_strobe_in, .ack_vector, .ack_vector_oe
);

// ---- verification/dci_host_model.sv ----
// ----------------------------------------
// Host acknowledge and upstream chain model
// ----------------------------------------
module dci_host_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ack_go,
    input wire logic upstream_busy,
    output logic chain_enable_in,
    output logic acknowledge_strobe_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;

    // Strobe held for a fixed stretch so the slave's synchroniser always sees it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 4'h0;
            chain_enable_in <= 1'b1;
            acknowledge_strobe_in <= 1'b0;
        end else begin
            chain_enable_in <= !upstream_busy;
            cnt_r <= ack_go ? 4'h8 : (cnt_r != 4'h0 ? cnt_r - 4'h1 : 4'h0);
            acknowledge_strobe_in <= ack_go || cnt_r > 4'h1;
        end
    end
endmodule // dci_host_model

// ---- verification/testbench.sv ----
`include "dci_params.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; $display("[ERR] %s expected %h seen %h", n, e, s); end end
// ----------------------------------------
// Interrupt chain bench
// ----------------------------------------
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk;
    logic hresetn;
    logic hsel, hwrite, ack_go, upstream_busy;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, q;
    logic [1:0][12:0] ev;
    logic [1:0][2:0] pins;
    wire logic hrdy, chain_in, chain_out, int_req_n, strobe, oe;
    wire logic [31:0] hrdata;
    wire logic [7:0] vec;
    wire logic [1:0] wait_n, dtr_n;
    int checked, miscompares, cyc;

    dci_top dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hrdy),
        .hreadyout(hrdy), .hresp(), .hrdata, .chain_enable_in(chain_in),
        .chain_enable_out(chain_out), .int_req_n, .acknowledge_strobe_in(strobe),
        .ack_vector(vec), .ack_vector_oe(oe), .ch_ev(ev), .ch_pins(pins),
        .wait_req_n(wait_n), .dtr_req_n(dtr_n)
    );
    dci_host_model host (
        .hclk, .hresetn, .ack_go, .upstream_busy,
        .chain_enable_in(chain_in), .acknowledge_strobe_in(strobe)
    );

    // Clock and hang guard
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 6000) begin
            miscompares++;
            test_done();
        end
    end

    // One single transfer; waits on ready in both phases, data taken at the closing edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0);
        `CHK(n, e, q)
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic pulse(input int c, input int b);
        ev[c][b] <= 1'b1;
        @(posedge hclk);
        ev[c][b] <= 1'b0;
        tick(2);
    endtask
    task automatic hw_ack();
        ack_go <= 1'b1;
        @(posedge hclk);
        ack_go <= 1'b0;
    endtask
    task automatic wait_oe(input logic v);
        for (int i = 0; i < 20 && oe !== v; i++) @(posedge hclk);
        `CHK("vector enable", v, oe)
    endtask
    // Pin edges pass a synchroniser, so allow a few edges before reading
    task automatic ext_seen(input string n);
        tick(4);
        rd(`DCI_OFS_PEND, 32'h20, n);
        bus(1'b1, `DCI_OFS_CMD, 32'h2000);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, ack_go, upstream_busy} = 4'h0;
        haddr = 8'h00;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ev = '0;
        pins = '0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b1, `DCI_OFS_MODE_A, 32'h1b);
        rd(`DCI_OFS_MODE_A, 32'h18, "mode enables");
        bus(1'b1, 8'h3c, 32'hff);
        rd(8'h3c, 32'h0, "unmapped");
        bus(1'b1, `DCI_OFS_VEC_B, 32'h80);
        rd(`DCI_OFS_VEC_A, 32'h80, "shared vector");
        bus(1'b1, `DCI_OFS_MASTER, 32'h09);
        bus(1'b1, `DCI_OFS_MODE_A, 32'h03);
        pulse(1, 9);
        rd(`DCI_OFS_PEND, 32'h0, "rx disabled");
        bus(1'b1, `DCI_OFS_MODE_B, 32'h10);
        pulse(1, 9);
        pulse(0, 6);
        rd(`DCI_OFS_PEND, 32'h14, "pending");
        `CHK("request", 1'b0, int_req_n)
        // Upstream device owns the chain: no request, acknowledge ignored
        upstream_busy <= 1'b1;
        tick(4);
        `CHK("request blocked", 1'b1, int_req_n)
        hw_ack();
        tick(10);
        rd(`DCI_OFS_ISRV, 32'h0, "blocked ack");
        upstream_busy <= 1'b0;
        tick(4);
        hw_ack();
        wait_oe(1'b1);
        `CHK("vector", {4'h8, `DCI_ST_A_EXT, 1'b0}, vec)
        `CHK("chain out", 1'b0, chain_out)
        rd(`DCI_OFS_ISRV, 32'h04, "in service");
        `CHK("lower blocked", 1'b1, int_req_n)
        pulse(0, 11);
        `CHK("nested request", 1'b0, int_req_n)
        wait_oe(1'b0);
        hw_ack();
        wait_oe(1'b1);
        `CHK("nested vector", {4'h8, `DCI_ST_A_TX, 1'b0}, vec)
        wait_oe(1'b0);
        bus(1'b1, `DCI_OFS_CMD, 32'h502);
        bus(1'b1, `DCI_OFS_CMD, 32'h2);
        rd(`DCI_OFS_ISRV, 32'h0, "services ended");
        bus(1'b1, `DCI_OFS_CMD, 32'h1);
        rd(`DCI_OFS_ISRV, 32'h10, "soft ack");
        `CHK("soft ack release", 1'b1, int_req_n)
        rd(`DCI_OFS_VEC_B, {24'h0, 4'h8, `DCI_ST_B_RX, 1'b0}, "status vector");
        rd(`DCI_OFS_VEC_A, 32'h80, "plain vector");
        bus(1'b1, `DCI_OFS_MASTER, 32'h08);
        rd(`DCI_OFS_VEC_B, 32'h80, "status off");
        bus(1'b1, `DCI_OFS_CMD, 32'h1002);
        rd(`DCI_OFS_PEND, 32'h0, "cleared");
        // First-character mode: one character, then only specials
        bus(1'b1, `DCI_OFS_MODE_B, 32'h08);
        pulse(1, 9);
        rd(`DCI_OFS_PEND, 32'h10, "first char");
        bus(1'b1, `DCI_OFS_CMD, 32'h1000);
        pulse(1, 9);
        rd(`DCI_OFS_PEND, 32'h0, "later char");
        pulse(1, 7);
        rd(`DCI_OFS_PEND, 32'h10, "special later");
        bus(1'b1, `DCI_OFS_CMD, 32'h1000);
        // Global gate off: the event latches but may not request
        bus(1'b1, `DCI_OFS_MASTER, 32'h00);
        pulse(0, 6);
        `CHK("gate off", 1'b1, int_req_n)
        bus(1'b1, `DCI_OFS_MASTER, 32'h08);
        tick(2);
        `CHK("gate on", 1'b0, int_req_n)
        bus(1'b1, `DCI_OFS_CMD, 32'h400);
        bus(1'b1, `DCI_OFS_MODE_B, 32'h18);
        pulse(1, 9);
        rd(`DCI_OFS_PEND, 32'h0, "special only");
        pulse(1, 7);
        rd(`DCI_OFS_PEND, 32'h10, "special");
        bus(1'b1, `DCI_OFS_CMD, 32'h1000);
        bus(1'b1, `DCI_OFS_EXT_B, 32'h08);
        ev[1][8] <= 1'b1;
        tick(3);
        rd(`DCI_OFS_PEND, 32'h10, "four bytes");
        ev[1][8] <= 1'b0;
        bus(1'b1, `DCI_OFS_CMD, 32'h1000);
        // Every external event cause and one pin edge; level causes also at their end
        bus(1'b1, `DCI_OFS_MODE_B, 32'h01);
        for (int b = 2; b < 7; b++) begin
            ev[1][b] <= 1'b1;
            @(posedge hclk);
            if (b > 4) ev[1][b] <= 1'b0;
            ext_seen("ext start");
            if (b < 5) begin
                ev[1][b] <= 1'b0;
                ext_seen("ext end");
            end
        end
        pins[1][2] <= 1'b1;
        ext_seen("pin edge");
        // Whole-FIFO-empty transmit interrupt needs a written character first
        bus(1'b1, `DCI_OFS_EXT_A, 32'h20);
        ev[0][10] <= 1'b1;
        pulse(0, 11);
        rd(`DCI_OFS_PEND, 32'h0, "empty unwritten");
        pulse(0, 12);
        pulse(0, 11);
        rd(`DCI_OFS_PEND, 32'h1, "fifo empty");
        bus(1'b1, `DCI_OFS_CMD, 32'h100);
        pulse(0, 11);
        rd(`DCI_OFS_PEND, 32'h0, "written once");
        ev[0][10] <= 1'b0;
        bus(1'b1, `DCI_OFS_EXT_A, 32'h00);
        pulse(0, 11);
        rd(`DCI_OFS_PEND, 32'h1, "top entry");
        bus(1'b1, `DCI_OFS_CMD, 32'h100);
        // Wait then request behaviour on channel A transmit readiness
        bus(1'b1, `DCI_OFS_MODE_A, 32'h40);
        tick(3);
        `CHK("wait not ready", 1'b0, wait_n[0])
        ev[0][0] <= 1'b1;
        tick(3);
        `CHK("wait ready", 1'b1, wait_n[0])
        bus(1'b1, `DCI_OFS_MODE_A, 32'h60);
        bus(1'b1, `DCI_OFS_EXT_A, 32'h10);
        tick(3);
        `CHK("request ready", 1'b0, wait_n[0])
        `CHK("dtr request", 1'b0, dtr_n[0])
        ev[0][0] <= 1'b0;
        tick(3);
        `CHK("dtr released", 1'b1, dtr_n[0])
        test_done();
    end
endmodule // testbench
